// ### pkg/epiu_pkg.sv
package epiu_pkg;

    // Register offsets in the I/O space.
    localparam logic [5:0] EPIU_OFS_PCM_HIGH = 6'h22;
    localparam logic [5:0] EPIU_OFS_PCM_LOW  = 6'h23;
    localparam logic [5:0] EPIU_OFS_CTRL     = 6'h35;
    localparam logic [5:0] EPIU_OFS_MASK     = 6'h3B;
    localparam logic [5:0] EPIU_OFS_FLAGS    = 6'h3A;

    // Reset values.
    localparam logic [7:0] EPIU_RST_PCM_HIGH = 8'hFF;
    localparam logic [7:0] EPIU_RST_PCM_LOW  = 8'hC8;
    localparam logic [7:0] EPIU_RST_CTRL     = 8'h00;
    localparam logic [7:0] EPIU_RST_MASK     = 8'h00;

    // Field positions.
    localparam int EPIU_BIT_PIN_ONE   = 7;
    localparam int EPIU_BIT_PIN_ZERO  = 6;
    localparam int EPIU_BIT_GROUP_A   = 5;
    localparam int EPIU_BIT_GROUP_B   = 4;
    localparam int EPIU_BIT_CHANGE    = 5;

    // Writable bits of the control and mask registers.
    localparam logic [7:0] EPIU_CTRL_WMASK = 8'h7B;
    localparam logic [7:0] EPIU_MASK_WMASK = 8'hF0;

    // Sense modes.
    typedef enum logic [1:0] {
        EPIU_SENSE_LOW  = 2'h0,
        EPIU_SENSE_ANY  = 2'h1,
        EPIU_SENSE_FALL = 2'h2,
        EPIU_SENSE_RISE = 2'h3
    } epiu_sense_t;

endpackage

// ### rtl/epiu_top.sv
`timescale 1ns/10ps
// Functional notes
// - Two-bit field selects low, change, fall, rise
// - Pins synchronised before edge detection
// - Mask bit 7 gates pin one requests
// - Mask bit 6 gates pin zero requests
// - Pins request even when driven as outputs
// - Mask bit 5 gates change inputs 7..0,15..12
// - Mask bit 4 gates change inputs 11..8
// - Both change groups share one request
// - Flag bit 7 sets on pin one event
// - Flag bit 6 sets on pin zero event
// - Flags clear on acknowledge or write one
// - Level mode flag reads as cleared
// - Flag bit 5 sets on enabled change
// - Reserved mask and flag bits read zero
// - Low change mask enables inputs 7:0
// - High mask qualified by group bits
// - Enabled change events feed a registered (clocked) wake
// - Level on pin zero wakes via clocked register if mask bit 6 set
// - Level mode requests while pin stays low
module epiu_top (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ext_pin_zero_i,
    input  wire logic        ext_pin_one_i,
    input  wire logic [15:0] change_inputs_i,
    input  wire logic        global_enable_i,
    input  wire logic [5:0]  io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic        ack_pin_zero_i,
    input  wire logic        ack_pin_one_i,
    input  wire logic        ack_change_i,
    output logic      [7:0]  io_rdata_o,
    output logic             req_pin_zero_o,
    output logic             req_pin_one_o,
    output logic             req_change_o,
    output logic             wake_o
);
    import epiu_pkg::*;

    logic [7:0]  pcm_high_reg;
    logic [7:0]  pcm_low_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [17:0] sync1_reg;
    logic [17:0] sync2_reg;
    logic [17:0] prev_reg;
    logic [15:0] chg_en;
    logic        ev_zero;
    logic        ev_one;
    logic        ev_chg;
    logic        low_mode;
    logic        lvl_zero;
    logic        lvl_one;
    logic [7:0]  flags_view;
    logic [7:0]  rdata_next;
    logic        wr_flags;
    epiu_sense_t sense;

    // Returns whether the sampled pin shows the selected edge; level mode returns zero.
    function automatic logic sense_hit(input epiu_sense_t mode,
                                       input logic now,
                                       input logic was);
        logic hit;
        hit = 1'b0;
        case (mode)
            EPIU_SENSE_LOW:  hit = 1'b0;
            EPIU_SENSE_ANY:  hit = now ^ was;
            EPIU_SENSE_FALL: hit = was & ~now;
            EPIU_SENSE_RISE: hit = now & ~was;
            default:         hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Two-stage synchroniser for all pins, read pin values regardless of
    // direction so software can drive them to raise requests.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 18'h3FFFF;
            sync2_reg <= 18'h3FFFF;
            prev_reg  <= 18'h3FFFF;
        end else begin
            sync1_reg <= {ext_pin_one_i, ext_pin_zero_i, change_inputs_i};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Per-input change enables from the masks and group bits.
    always_comb begin
        chg_en[7:0]   = pcm_low_reg & {8{mask_reg[EPIU_BIT_GROUP_A]}};
        chg_en[11:8]  = pcm_high_reg[3:0]
                      & {4{mask_reg[EPIU_BIT_GROUP_B]}};
        chg_en[15:12] = pcm_high_reg[7:4]
                      & {4{mask_reg[EPIU_BIT_GROUP_A]}};
    end

    // Event detection on the sampled pins.
    assign sense    = epiu_sense_t'(ctrl_reg[1:0]);
    assign low_mode = (sense == EPIU_SENSE_LOW);
    assign ev_zero  = sense_hit(sense, sync2_reg[16], prev_reg[16]);
    assign ev_one   = sense_hit(sense, sync2_reg[17], prev_reg[17]);
    assign ev_chg   = |((sync2_reg[15:0] ^ prev_reg[15:0]) & chg_en);
    assign lvl_zero = low_mode & ~sync2_reg[16];
    assign lvl_one  = low_mode & ~sync2_reg[17];
    assign wr_flags = io_wr_i && (io_addr_i == EPIU_OFS_FLAGS);

    // Pending flags: a new event wins over a clear in the same cycle.
    always_comb begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = flags_next & ~io_wdata_i;
        end
        if (ack_pin_one_i) begin
            flags_next[EPIU_BIT_PIN_ONE] = 1'b0;
        end
        if (ack_pin_zero_i) begin
            flags_next[EPIU_BIT_PIN_ZERO] = 1'b0;
        end
        if (ack_change_i) begin
            flags_next[EPIU_BIT_CHANGE] = 1'b0;
        end
        if (ev_one) begin
            flags_next[EPIU_BIT_PIN_ONE] = 1'b1;
        end
        if (ev_zero) begin
            flags_next[EPIU_BIT_PIN_ZERO] = 1'b1;
        end
        if (ev_chg) begin
            flags_next[EPIU_BIT_CHANGE] = 1'b1;
        end
        if (low_mode) begin
            flags_next[EPIU_BIT_PIN_ONE]  = 1'b0;
            flags_next[EPIU_BIT_PIN_ZERO] = 1'b0;
        end
        flags_next[4:0] = 5'h00;
    end

    // Flag storage.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= 8'h00;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Software-written configuration registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcm_high_reg <= EPIU_RST_PCM_HIGH;
            pcm_low_reg  <= EPIU_RST_PCM_LOW;
            ctrl_reg     <= EPIU_RST_CTRL;
            mask_reg     <= EPIU_RST_MASK;
        end else if (io_wr_i) begin
            case (io_addr_i)
                EPIU_OFS_PCM_HIGH: pcm_high_reg <= io_wdata_i;
                EPIU_OFS_PCM_LOW:  pcm_low_reg  <= io_wdata_i;
                EPIU_OFS_CTRL:     ctrl_reg <= io_wdata_i & EPIU_CTRL_WMASK;
                EPIU_OFS_MASK:     mask_reg <= io_wdata_i & EPIU_MASK_WMASK;
                default:           ;
            endcase
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    assign flags_view = flags_reg;
    always_comb begin
        rdata_next = 8'h00;
        if (io_rd_i) begin
            case (io_addr_i)
                EPIU_OFS_PCM_HIGH: rdata_next = pcm_high_reg;
                EPIU_OFS_PCM_LOW:  rdata_next = pcm_low_reg;
                EPIU_OFS_CTRL:     rdata_next = ctrl_reg;
                EPIU_OFS_MASK:     rdata_next = mask_reg;
                EPIU_OFS_FLAGS:    rdata_next = flags_view;
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    // Registered outputs: gated requests as levels to the core.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_rdata_o     <= 8'h00;
            req_pin_zero_o <= 1'b0;
            req_pin_one_o  <= 1'b0;
            req_change_o   <= 1'b0;
            wake_o         <= 1'b0;
        end else begin
            io_rdata_o     <= rdata_next;
            req_pin_one_o  <= global_enable_i & mask_reg[EPIU_BIT_PIN_ONE]
                            & (flags_next[EPIU_BIT_PIN_ONE] | lvl_one);
            req_pin_zero_o <= global_enable_i & mask_reg[EPIU_BIT_PIN_ZERO]
                            & (flags_next[EPIU_BIT_PIN_ZERO] | lvl_zero);
            req_change_o   <= global_enable_i
                            & (mask_reg[EPIU_BIT_GROUP_A]
                            | mask_reg[EPIU_BIT_GROUP_B])
                            & flags_next[EPIU_BIT_CHANGE];
            wake_o         <= ev_chg | (mask_reg[EPIU_BIT_PIN_ZERO]
                            & lvl_zero);
        end
    end

    // Checks.
    a_flag_set_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ev_one && !low_mode) |=> flags_reg[7])
        else $error("pin one flag not set");
    a_flag_set_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ev_zero && !low_mode) |=> flags_reg[6])
        else $error("pin zero flag not set");
    a_change_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev_chg |=> flags_reg[5])
        else $error("change flag not set");
    a_low_mode_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(low_mode) |-> flags_reg[7:6] == 2'h0)
        else $error("flag set in level mode");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flags_reg[4:0] == 5'h00 && mask_reg[3:0] == 4'h0)
        else $error("reserved bit set");
    a_write_one_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_flags && io_wdata_i[5] && !ev_chg) |=> !flags_reg[5])
        else $error("write one did not clear");
    a_pin_one_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_pin_one_o |-> $past(global_enable_i && mask_reg[7]))
        else $error("pin one request ungated");
    a_pin_zero_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_pin_zero_o |-> $past(global_enable_i && mask_reg[6]))
        else $error("pin zero request ungated");
    a_level_request: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lvl_zero && global_enable_i && mask_reg[6]) |=> req_pin_zero_o)
        else $error("level request missing");
    a_group_b_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mask_reg[4] |-> chg_en[11:8] == 4'h0)
        else $error("group b not gated");

    // Gating by the global enable and the per-source enables.
    a_change_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_change_o |-> $past(global_enable_i))
        else $error("change request ungated");
    a_one_global_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !global_enable_i |=> !req_pin_one_o)
        else $error("pin one request without global enable");
    a_zero_global_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !global_enable_i |=> !req_pin_zero_o)
        else $error("pin zero request without global enable");
    a_chg_global_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !global_enable_i |=> !req_change_o)
        else $error("change request without global enable");
    a_one_mask_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mask_reg[7] |=> !req_pin_one_o)
        else $error("pin one request while masked");
    a_zero_mask_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mask_reg[6] |=> !req_pin_zero_o)
        else $error("pin zero request while masked");
    a_chg_group_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(mask_reg[5] || mask_reg[4]) |=> !req_change_o)
        else $error("change request with both groups off");

    // Sense decoding on the sampled pins.
    a_sense_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sense == EPIU_SENSE_FALL && prev_reg[16] && !sync2_reg[16])
        |=> flags_reg[6])
        else $error("falling edge missed");
    a_sense_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sense == EPIU_SENSE_RISE && !prev_reg[17] && sync2_reg[17])
        |=> flags_reg[7])
        else $error("rising edge missed");
    a_sense_any: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sense == EPIU_SENSE_ANY && sync2_reg[16] != prev_reg[16])
        |=> flags_reg[6])
        else $error("pin change missed");
    a_rise_no_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sense == EPIU_SENSE_RISE && !flags_reg[6]
        && !(sync2_reg[16] && !prev_reg[16])) |=> !flags_reg[6])
        else $error("flag set without a rising edge");

    // Clearing by acknowledge and by software writes; a new event wins.
    a_ack_one_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ack_pin_one_i && !ev_one) |=> !flags_reg[7])
        else $error("acknowledge left pin one flag set");
    a_ack_zero_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ack_pin_zero_i && !ev_zero) |=> !flags_reg[6])
        else $error("acknowledge left pin zero flag set");
    a_ack_chg_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ack_change_i && !ev_chg) |=> !flags_reg[5])
        else $error("acknowledge left change flag set");
    a_write_one_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_flags && io_wdata_i[7] && !ev_one) |=> !flags_reg[7])
        else $error("write one left pin one flag set");
    a_keep_pin_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_reg[7] && !low_mode && !ack_pin_one_i
        && !(wr_flags && io_wdata_i[7])) |=> flags_reg[7])
        else $error("pin one flag lost");
    a_keep_change: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_reg[5] && !ack_change_i
        && !(wr_flags && io_wdata_i[5])) |=> flags_reg[5])
        else $error("change flag lost");

    // Requests stand while their flags stay pending and enabled.
    a_req_one_stands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_reg[7] && mask_reg[7] && global_enable_i && !low_mode
        && !ack_pin_one_i && !wr_flags) |=> req_pin_one_o)
        else $error("pin one request dropped");
    a_req_zero_stands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_reg[6] && mask_reg[6] && global_enable_i && !low_mode
        && !ack_pin_zero_i && !wr_flags) |=> req_pin_zero_o)
        else $error("pin zero request dropped");
    a_req_chg_stands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_reg[5] && (mask_reg[5] || mask_reg[4]) && global_enable_i
        && !ack_change_i && !wr_flags) |=> req_change_o)
        else $error("change request dropped");

    // Level sensing and wake-up.
    a_level_one_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lvl_one && global_enable_i && mask_reg[7]) |=> req_pin_one_o)
        else $error("pin one level request missing");
    a_level_gone: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (low_mode && sync2_reg[16]) |=> !req_pin_zero_o)
        else $error("level request while pin high");
    a_wake_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lvl_zero && mask_reg[6]) |=> wake_o)
        else $error("level wake missing");
    a_wake_change: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev_chg |=> wake_o)
        else $error("change wake missing");
    a_wake_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wake_o |-> $past(ev_chg || (lvl_zero && mask_reg[6])))
        else $error("wake without a cause");

    // Change enables and reserved read bits.
    a_group_a_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mask_reg[5] |-> (chg_en[7:0] == 8'h00
        && chg_en[15:12] == 4'h0))
        else $error("group a not gated");
    a_low_mask_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mask_reg[5] |-> chg_en[7:0] == pcm_low_reg)
        else $error("low change mask not applied");
    a_high_mask_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mask_reg[5] && mask_reg[4]) |-> chg_en[15:8] == pcm_high_reg)
        else $error("high change mask not applied");
    a_masked_no_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((((sync2_reg[15:0] ^ prev_reg[15:0]) & chg_en) == 16'h0000)
        && !flags_reg[5]) |=> !flags_reg[5])
        else $error("change flag from a disabled input");
    a_flag_read_res: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(io_rd_i) && $past(io_addr_i) == EPIU_OFS_FLAGS)
        |-> io_rdata_o[4:0] == 5'h00)
        else $error("reserved flag bits read set");
    a_mask_read_res: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(io_rd_i) && $past(io_addr_i) == EPIU_OFS_MASK)
        |-> io_rdata_o[3:0] == 4'h0)
        else $error("reserved mask bits read set");

    // Two-stage sampling of the dedicated pins.
    a_two_stage: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sync2_reg[17:16] == $past({ext_pin_one_i, ext_pin_zero_i}, 2))
        else $error("pin sampling delay wrong");

endmodule

// ### verif/epiu_core_model.sv
`timescale 1ns/10ps
// Core side: answers each pending request with a one-cycle acknowledge.
module epiu_core_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ack_en_i,
    input  wire logic req_pin_zero_i,
    input  wire logic req_pin_one_i,
    input  wire logic req_change_i,
    output logic      ack_pin_zero_o,
    output logic      ack_pin_one_o,
    output logic      ack_change_o
);
    // A pulse never repeats on the next edge, so the flag has time to drop.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_pin_zero_o <= 1'b0;
            ack_pin_one_o  <= 1'b0;
            ack_change_o   <= 1'b0;
        end else begin
            ack_pin_zero_o <= ack_en_i & req_pin_zero_i & ~ack_pin_zero_o;
            ack_pin_one_o  <= ack_en_i & req_pin_one_i & ~ack_pin_one_o;
            ack_change_o   <= ack_en_i & req_change_i & ~ack_change_o;
        end
    end
endmodule

// ### verif/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin #1 n_compared++; if ((a) !== (b)) begin \
    error_cnt++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
    import epiu_pkg::*;
    typedef struct packed {
        logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;
    } epiu_tb_row_t;
    // Reset values, unmapped reads and read-only bits after a write.
    localparam epiu_tb_row_t ROWS [9] = '{
        '{1'b0, EPIU_OFS_PCM_HIGH, 8'h00, 8'hFF},
        '{1'b0, EPIU_OFS_PCM_LOW, 8'h00, 8'hC8},
        '{1'b0, EPIU_OFS_CTRL, 8'h00, 8'h00},
        '{1'b0, EPIU_OFS_MASK, 8'h00, 8'h00},
        '{1'b0, EPIU_OFS_FLAGS, 8'h00, 8'h00},
        '{1'b0, 6'h10, 8'h00, 8'h00},
        '{1'b1, EPIU_OFS_CTRL, 8'hFF, 8'h7B},
        '{1'b1, EPIU_OFS_MASK, 8'hFF, 8'hF0},
        '{1'b1, 6'h10, 8'h55, 8'h00}};
    logic clk_i = 1'b0, rst_n_i = 1'b0, p0 = 1'b1, p1 = 1'b1, ge = 1'b1;
    logic [15:0] chg = 16'h0000;
    logic [5:0]  io_addr_i = 6'h00;
    logic        io_wr_i = 1'b0, io_rd_i = 1'b0, ack_en = 1'b0;
    logic [7:0]  io_wdata_i = 8'h00, io_rdata_o, rv;
    logic        a0, a1, ac, r0, r1, rc, wake_o;
    int          error_cnt = 0, n_compared = 0;
    // The clock runs at 250 MHz.
    always #2 clk_i = ~clk_i;
    epiu_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_pin_zero_i(p0),
        .ext_pin_one_i(p1), .change_inputs_i(chg), .global_enable_i(ge),
        .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i), .ack_pin_zero_i(a0), .ack_pin_one_i(a1),
        .ack_change_i(ac), .io_rdata_o(io_rdata_o), .req_pin_zero_o(r0),
        .req_pin_one_o(r1), .req_change_o(rc), .wake_o(wake_o));
    epiu_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .ack_en_i(ack_en),
        .req_pin_zero_i(r0), .req_pin_one_i(r1), .req_change_i(rc),
        .ack_pin_zero_o(a0), .ack_pin_one_o(a1), .ack_change_o(ac));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i) begin io_addr_i <= a; io_wdata_i <= d; io_wr_i <= 1; end
        @(posedge clk_i) io_wr_i <= 1'b0;
    endtask
    // Read data is registered at the edge that samples the strobe.
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_i) begin io_addr_i <= a; io_rd_i <= 1'b1; end
        @(posedge clk_i) io_rd_i <= 1'b0;
        #1 rv = io_rdata_o;
        `CHK(rv, e, "read data")
    endtask
    // Toggles one change input and checks the shared request.
    task automatic chg_ev(input int i, input logic e);
        @(posedge clk_i) chg[i] <= ~chg[i];
        cyc(6);
        `CHK(rc, e, "change request")
        wr(EPIU_OFS_FLAGS, 8'h20);
        cyc(2);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Guards against a hang anywhere in the sequence.
    initial begin
        #200000 error_cnt++;
        give_verdict();
    end
    initial begin
        cyc(5);
        rst_n_i <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
            chk_rd(ROWS[i].a, ROWS[i].e);
        end
        $display("test registers done");
        wr(EPIU_OFS_MASK, 8'h80);
        for (int m = 1; m < 4; m++) begin
            wr(EPIU_OFS_CTRL, 8'(m));
            wr(EPIU_OFS_FLAGS, 8'hE0);
            @(posedge clk_i) p1 <= 1'b0;
            cyc(6);
            `CHK(r1, 1'(m != 3), "falling request")
            wr(EPIU_OFS_FLAGS, 8'h00);
            chk_rd(EPIU_OFS_FLAGS, {m != 3, 7'h00});
            wr(EPIU_OFS_FLAGS, 8'h80);
            cyc(2);
            `CHK(r1, 1'b0, "write one clears")
            @(posedge clk_i) p1 <= 1'b1;
            cyc(6);
            `CHK(r1, 1'(m != 2), "rising request")
            wr(EPIU_OFS_FLAGS, 8'h80);
        end
        $display("test sense modes done");
        wr(EPIU_OFS_CTRL, 8'h02);
        @(posedge clk_i) p0 <= 1'b0;
        cyc(6);
        `CHK(r0, 1'b0, "masked pin zero")
        chk_rd(EPIU_OFS_FLAGS, 8'h40);
        wr(EPIU_OFS_MASK, 8'h40);
        @(posedge clk_i) ge <= 1'b0;
        cyc(3);
        `CHK(r0, 1'b0, "global disable")
        @(posedge clk_i) ge <= 1'b1;
        cyc(3);
        `CHK(r0, 1'b1, "enabled pin zero")
        @(posedge clk_i) ack_en <= 1'b1;
        cyc(5);
        ack_en <= 1'b0;
        `CHK(r0, 1'b0, "acknowledge clears")
        chk_rd(EPIU_OFS_FLAGS, 8'h00);
        @(posedge clk_i) p0 <= 1'b1;
        $display("test gating done");
        wr(EPIU_OFS_CTRL, 8'h00);
        @(posedge clk_i) p0 <= 1'b0;
        cyc(6);
        `CHK(wake_o, 1'b1, "level wake")
        chk_rd(EPIU_OFS_FLAGS, 8'h00);
        cyc(20);
        `CHK(r0, 1'b1, "level held")
        @(posedge clk_i) p0 <= 1'b1;
        cyc(6);
        `CHK(r0, 1'b0, "level gone")
        $display("test level mode done");
        wr(EPIU_OFS_MASK, 8'h20);
        wr(EPIU_OFS_PCM_LOW, 8'h01);
        wr(EPIU_OFS_PCM_HIGH, 8'h11);
        chg_ev(0, 1'b1);
        chg_ev(1, 1'b0);
        chg_ev(12, 1'b1);
        chg_ev(8, 1'b0);
        wr(EPIU_OFS_MASK, 8'h10);
        chg_ev(8, 1'b1);
        chg_ev(12, 1'b0);
        $display("test pin change done");
        wr(EPIU_OFS_MASK, 8'h80);
        wr(EPIU_OFS_CTRL, 8'h01);
        @(posedge clk_i) p1 <= 1'b0;
        cyc(1);
        @(posedge clk_i) p1 <= 1'b1;
        cyc(6);
        `CHK(r1, 1'b1, "short pulse request")
        chk_rd(EPIU_OFS_FLAGS, 8'h80);
        wr(EPIU_OFS_FLAGS, 8'h80);
        $display("test short pulse done");
        @(posedge clk_i) rst_n_i <= 1'b0;
        cyc(2);
        `CHK({r0, r1, rc, wake_o, io_rdata_o}, 12'h000, "reset outputs")
        @(posedge clk_i) rst_n_i <= 1'b1;
        chk_rd(EPIU_OFS_CTRL, EPIU_RST_CTRL);
        chk_rd(EPIU_OFS_MASK, EPIU_RST_MASK);
        chk_rd(EPIU_OFS_PCM_LOW, EPIU_RST_PCM_LOW);
        $display("test mid reset done");
        give_verdict();
    end
endmodule
